/* File: rtl/isb_pkg.sv */
package isb_pkg;
    // pin and request widths
    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;
    localparam int WAIT_W = 4;
    // address fields: dram row/column lanes and cascade lanes
    localparam int DRAM_LO = 1;
    localparam int DRAM_HI = 12;
    localparam int ROW_LO = 13;
    localparam int CASC_LO = 23;
    localparam int CASC_HI = 25;
    // strap settle: reset clears both synchroniser stages, so a pin sample
    // needs two edges after release to reach the second stage
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_T1 = 3'b001,
        ST_T2 = 3'b010,
        ST_T3 = 3'b011,
        ST_END = 3'b100
    } isb_state_t;

    typedef enum logic [2:0] {
        KIND_IORD = 3'b000,
        KIND_IOWR = 3'b001,
        KIND_MEMRD = 3'b010,
        KIND_MEMWR = 3'b011,
        KIND_INTACK = 3'b100,
        KIND_DRAM = 3'b101,
        KIND_INTERNAL = 3'b110
    } isb_kind_t;

    typedef struct packed {
        isb_state_t st;
        isb_kind_t kind;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] reqAddr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic [WAIT_W-1:0] waitCnt;
        logic [WAIT_W-1:0] waitProg;
        logic hiByte;
        logic forceWide;
        logic wide;
        logic rspWide;
        logic ready;
        logic done;
        logic busOeN;
        logic dataOeN;
        logic hbOeN;
        logic hbN;
        logic wfOeN;
        logic iorN;
        logic iowN;
        logic memrN;
        logic memwN;
        logic [1:0] strapCnt;
        logic emu;
        logic bootWide;
        logic rdyS1;
        logic rdyS2;
        logic wfS1;
        logic wfS2;
        logic a0S1;
        logic a0S2;
        logic hbS1;
        logic hbS2;
        logic [DATA_W-1:0] datS1;
        logic [DATA_W-1:0] datS2;
    } isb_regs_t;

    // all pins floated, strobes idle, strap capture pending
    localparam isb_regs_t REGS_RST = '{st: ST_IDLE, kind: KIND_IORD,
        busOeN: 1'b1, dataOeN: 1'b1, hbOeN: 1'b1, hbN: 1'b1, wfOeN: 1'b1,
        iorN: 1'b1, iowN: 1'b1, memrN: 1'b1, memwN: 1'b1,
        strapCnt: STRAP_SETTLE, default: '0};
endpackage

/* File: rtl/isb_bus_unit.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - address outputs hold latched access address
// - dram row then column on lines 12:1
// - cascade lines onto address 25:23 in ack
// - address bit 0 strap selects float mode
// - 16-bit data bus, upper lanes unused narrow
// - high strobe low when odd byte moves
// - high strobe strap gives boot rom width
// - io read strobe low for io reads
// - io write strobe low during io writes
// - memory read strobe low for memory reads
// - memory write strobe low for memory writes
// - feedback low makes access 16-bit, else 8
// - forced-wide region drives feedback low itself
// - ready low stretches the external cycle
// - internal and fastest io take three states
// - waits combine programmed count and ready
module isb_bus_unit
    import isb_pkg::*;
(
    input wire logic clk,                       // 25 MHz t-state clock
    input wire logic sys_rst,                   // sync reset, active high
    input wire logic reqValid,                  // access request
    input wire logic [2:0] reqKind,             // isb_kind_t code
    input wire logic [ADDR_W-1:0] reqAddr,      // byte address
    input wire logic [DATA_W-1:0] reqWrData,    // write data
    input wire logic reqHighByte,               // odd byte takes part
    input wire logic [2:0] reqCascade,          // master cascade lines
    input wire logic reqForce16,                // region forces wide
    input wire logic [WAIT_W-1:0] reqWaitStates, // programmed waits
    output logic reqReady,                      // idle, request taken
    output logic rspDone,                       // one-cycle completion
    output logic [DATA_W-1:0] rspRdData,        // read data
    output logic rspWide,                       // access ran 16-bit
    output logic emulatorFloatMode,             // strapped float mode
    output logic bootRomWide,                   // strapped 16-bit boot
    output logic [ADDR_W-1:0] systemAddressBus, // address pins
    output logic addressOeN,                    // addr/strobes enable
    input wire logic addrStrapIn,               // level on address bit 0
    input wire logic [DATA_W-1:0] systemDataBusIn, // data pins in
    output logic [DATA_W-1:0] systemDataBusOut, // data pins out
    output logic systemDataBusOeN,              // data enable, low drive
    input wire logic highByteStrobeIn,          // high strobe pin level
    output logic highByteStrobeN,               // high strobe out
    output logic highByteStrobeOeN,             // high strobe enable
    output logic ioReadStrobeN,                 // io read command
    output logic ioWriteStrobeN,                // io write command
    output logic memReadStrobeN,                // memory read command
    output logic memWriteStrobeN,               // memory write command
    input wire logic wideDeviceFeedbackIn,      // wide feedback level
    output logic wideDeviceFeedbackOut,         // always low when driven
    output logic wideDeviceFeedbackOeN,         // open-drain enable
    input wire logic readyIn                    // wait-state ready
);
    isb_regs_t q;
    isb_regs_t d;

    // external cycles obey ready and programmed waits, internal ones not
    function automatic logic isExternal(input isb_kind_t k);
        return k != KIND_INTERNAL;
    endfunction

    // next state of the whole unit
    always_comb begin
        d = q;
        d.done = 1'b0;
        // two-stage synchronisers; first stage feeds only the second
        d.rdyS1 = readyIn;
        d.rdyS2 = q.rdyS1;
        d.wfS1 = wideDeviceFeedbackIn;
        d.wfS2 = q.wfS1;
        d.a0S1 = addrStrapIn;
        d.a0S2 = q.a0S1;
        d.hbS1 = highByteStrobeIn;
        d.hbS2 = q.hbS1;
        d.datS1 = systemDataBusIn;
        d.datS2 = q.datS1;
        if (q.strapCnt != 2'h0) begin
            // straps are read only once the synchronisers hold pin levels
            d.strapCnt = q.strapCnt - 2'h1;
            if (q.strapCnt == 2'h1) begin
                d.emu = ~q.a0S2;
                d.bootWide = ~q.hbS2;
                d.busOeN = ~q.a0S2;
                d.hbOeN = ~q.a0S2;
                d.ready = 1'b1;
            end
        end
        case (q.st)
            ST_IDLE: begin
                if (q.ready && reqValid) begin
                    d.st = ST_T1;
                    d.ready = 1'b0;
                    d.kind = isb_kind_t'(reqKind);
                    d.reqAddr = reqAddr;
                    d.addr = reqAddr;
                    if (isb_kind_t'(reqKind) == KIND_DRAM) begin
                        d.addr[DRAM_HI:DRAM_LO] =
                            reqAddr[ROW_LO+DRAM_HI-DRAM_LO:ROW_LO];
                    end
                    if (isb_kind_t'(reqKind) == KIND_INTACK) begin
                        d.addr[CASC_HI:CASC_LO] = reqCascade;
                    end
                    // a lone odd byte is copied to the low lane too so an
                    // 8-bit target still sees it
                    d.wdata = (reqHighByte && reqAddr[0]) ?
                        {reqWrData[15:8], reqWrData[15:8]} : reqWrData;
                    d.hiByte = reqHighByte;
                    d.forceWide = reqForce16;
                    d.waitProg = reqWaitStates;
                    d.dataOeN = q.emu ||
                        !(isb_kind_t'(reqKind) == KIND_IOWR ||
                          isb_kind_t'(reqKind) == KIND_MEMWR);
                    d.hbN = ~reqHighByte;
                    d.wfOeN = q.emu || !reqForce16;
                end
            end
            ST_T1: begin
                d.st = ST_T2;
                if (q.kind == KIND_DRAM) begin
                    d.addr[DRAM_HI:DRAM_LO] = q.reqAddr[DRAM_HI:DRAM_LO];
                end
                // only one command per cycle, chosen by kind
                d.iorN = q.kind != KIND_IORD;
                d.iowN = q.kind != KIND_IOWR;
                d.memrN = q.kind != KIND_MEMRD;
                d.memwN = q.kind != KIND_MEMWR;
                d.waitCnt = isExternal(q.kind) ? q.waitProg : '0;
            end
            ST_T2: begin
                d.st = ST_T3;
            end
            ST_T3: begin
                // feedback synced two edges late: only from t3 on does it
                // reflect the target decoding this access's address
                d.wide = q.forceWide || !q.wfS2;
                // ready is two cycles late through the synchroniser, so a
                // target must pull it low in t1, before the strobes go low
                if (q.waitCnt != '0) begin
                    d.waitCnt = q.waitCnt - 1'b1;
                end else if (!isExternal(q.kind) || q.rdyS2) begin
                    d.st = ST_END;
                    d.iorN = 1'b1;
                    d.iowN = 1'b1;
                    d.memrN = 1'b1;
                    d.memwN = 1'b1;
                end
            end
            ST_END: begin
                d.st = ST_IDLE;
                d.done = 1'b1;
                d.ready = 1'b1;
                d.rspWide = q.wide;
                d.rdata = q.wide ? q.datS2 : {8'h00, q.datS2[7:0]};
                d.dataOeN = 1'b1;
                d.wfOeN = 1'b1;
                d.hbN = 1'b1;
            end
            default: d.st = ST_IDLE;
        endcase
    end

    // one register bank for the whole unit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    // every output but the constant feedback level comes straight from the register bank
    assign reqReady = q.ready;
    assign rspDone = q.done;
    assign rspRdData = q.rdata;
    assign rspWide = q.rspWide;
    assign emulatorFloatMode = q.emu;
    assign bootRomWide = q.bootWide;
    assign systemAddressBus = q.addr;
    assign addressOeN = q.busOeN;
    assign systemDataBusOut = q.wdata;
    assign systemDataBusOeN = q.dataOeN;
    assign highByteStrobeN = q.hbN;
    assign highByteStrobeOeN = q.hbOeN;
    assign ioReadStrobeN = q.iorN;
    assign ioWriteStrobeN = q.iowN;
    assign memReadStrobeN = q.memrN;
    assign memWriteStrobeN = q.memwN;
    assign wideDeviceFeedbackOut = 1'b0;
    assign wideDeviceFeedbackOeN = q.wfOeN;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence takeSeq;
        q.ready && reqValid && q.st == ST_IDLE;
    endsequence
    sequence minCycleSeq;
        q.st == ST_T1 ##1 q.st == ST_T2 ##1 q.st == ST_T3;
    endsequence

    chk_min_states: assert property (takeSeq |=> minCycleSeq)
        else $error("access did not step through three states");
    chk_addr_hold: assert property ((q.st == ST_T3 && q.kind != KIND_DRAM)
        |-> q.addr == $past(q.addr, 2))
        else $error("address changed during access");
    chk_dram_column: assert property ((q.st == ST_T2 && q.kind == KIND_DRAM)
        |-> q.addr[DRAM_HI:DRAM_LO] == q.reqAddr[DRAM_HI:DRAM_LO])
        else $error("dram column not on address lines");
    chk_cascade_lines: assert property ((takeSeq and
        (isb_kind_t'(reqKind) == KIND_INTACK))
        |=> q.addr[CASC_HI:CASC_LO] == $past(reqCascade))
        else $error("cascade lines not on upper address");
    chk_strap_float: assert property ((q.strapCnt == 2'h1)
        |=> q.emu == ~$past(q.a0S2) && q.busOeN == q.emu)
        else $error("float strap not captured");
    chk_boot_width: assert property ((q.strapCnt == 2'h1)
        |=> q.bootWide == ~$past(q.hbS2))
        else $error("boot width strap not captured");
    chk_narrow_lane: assert property ((q.done && !q.rspWide)
        |-> q.rdata[15:8] == 8'h00)
        else $error("upper lanes used on narrow access");
    chk_high_strobe: assert property ((q.st == ST_T2)
        |-> q.hbN == ~q.hiByte)
        else $error("high strobe does not follow odd byte");
    chk_io_read: assert property ((q.st == ST_T1 && q.kind == KIND_IORD)
        |=> !q.iorN [*2])
        else $error("io read strobe missing");
    chk_io_write: assert property ((q.st == ST_T1 && q.kind == KIND_IOWR)
        |=> !q.iowN [*2])
        else $error("io write strobe missing");
    chk_mem_read: assert property ((q.st == ST_T1 && q.kind == KIND_MEMRD)
        |=> !q.memrN [*2])
        else $error("memory read strobe missing");
    chk_mem_write: assert property ((q.st == ST_T1 && q.kind == KIND_MEMWR)
        |=> !q.memwN [*2])
        else $error("memory write strobe missing");
    chk_wide_sample: assert property ((q.st == ST_T3)
        |=> q.wide == (q.forceWide || !$past(q.wfS2)))
        else $error("width not taken from feedback");
    chk_force_wide: assert property ((q.st == ST_T2 && q.forceWide && !q.emu)
        |-> !q.wfOeN)
        else $error("forced region not driving feedback");
    chk_ready_wait: assert property ((q.st == ST_T3 && q.waitCnt == '0 &&
        q.kind != KIND_INTERNAL && !q.rdyS2) |=> q.st == ST_T3)
        else $error("cycle ended while ready low");
    chk_prog_wait: assert property ((q.st == ST_T3 && q.waitCnt != '0)
        |=> q.st == ST_T3 && q.waitCnt == $past(q.waitCnt) - 1'b1)
        else $error("programmed wait not honoured");
    chk_one_strobe: assert property ($onehot0({~q.iorN, ~q.iowN,
        ~q.memrN, ~q.memwN}))
        else $error("more than one command strobe");
endmodule
`default_nettype wire

/* File: test/isb_periph_model.sv */
`timescale 1ns/10ps
`default_nettype none
// isa-style target: address bit 20 decodes wide, bit 21 decodes slow
module isb_periph_model
    import isb_pkg::*;
#(
    parameter int SLOW_WAITS = 3
) (
    input wire logic clk,                 // bus clock
    input wire logic [ADDR_W-1:0] addr,   // address pins
    input wire logic iorN,                // io read pin
    input wire logic iowN,                // io write pin
    input wire logic memrN,               // memory read pin
    input wire logic memwN,               // memory write pin
    input wire logic hbN,                 // high strobe pin
    input wire logic [DATA_W-1:0] dataIn, // data pin level
    output logic [DATA_W-1:0] dataOut,    // read data
    output logic [1:0] dataOe,            // lane drive, high drives
    output logic fbPull,                  // pulls feedback low
    output logic rdyPull                  // pulls ready low
);
    logic [DATA_W-1:0] mem [0:7];
    logic [3:0] busyCnt;
    logic wide;
    logic rd;
    logic wr;
    assign wide = addr[20];
    assign rd = !iorN || !memrN;
    assign wr = !iowN || !memwN;
    // open collector: the line is only ever pulled, never driven high
    assign fbPull = wide;
    // a narrow target never touches the upper lanes, strobe or not
    assign dataOe = rd ? {wide && !hbN, 1'b1} : 2'h0;
    assign dataOut = mem[addr[3:1]];
    // slow decode holds ready low until the command has run a while
    assign rdyPull = addr[21] && busyCnt < SLOW_WAITS;
    // writes land every strobe cycle; repeats of the same word are harmless
    always_ff @(posedge clk) begin
        busyCnt <= (rd || wr) ? busyCnt + 4'h1 : 4'h0;
        if (wr && !addr[0]) mem[addr[3:1]][7:0] <= dataIn[7:0];
        if (wr && wide && !hbN) mem[addr[3:1]][15:8] <= dataIn[15:8];
    end
endmodule
`default_nettype wire

/* File: test/isb_bus_unit_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module isb_bus_unit_tb;
    import isb_pkg::*;
    logic clk = 0, sys_rst = 1, reqValid = 0, reqHighByte = 0, reqForce16 = 0;
    logic [2:0] reqKind = 0, reqCascade = 0;
    logic [ADDR_W-1:0] reqAddr = 0, sysAddr, a1, a2;
    logic [DATA_W-1:0] reqWrData = 0, rdData, dOut, mOut, sdBus, sdLast = 0;
    logic [WAIT_W-1:0] reqWaitStates = 0;
    logic reqReady, rspDone, rspWide, emu, bootW, aOeN, dOeN, hbN, hbOeN;
    logic iorN, iowN, memrN, memwN, fbOut, fbOeN, fbPull, rdyPull;
    logic strapA0 = 1, strapHb = 0, hbSeen, fbSeen, oeSeen;
    logic [1:0] mOe;
    logic [3:0] stb;
    int errors = 0, checks_done = 0, cycles = 0, lat;
    // released data lanes show the inverse of their last level
    assign sdBus = !dOeN ? dOut : {mOe[1] ? mOut[15:8] : ~sdLast[15:8],
        mOe[0] ? mOut[7:0] : ~sdLast[7:0]};
    isb_bus_unit dut_u (.clk(clk), .sys_rst(sys_rst), .reqValid(reqValid),
        .reqKind(reqKind), .reqAddr(reqAddr), .reqWrData(reqWrData),
        .reqHighByte(reqHighByte), .reqCascade(reqCascade),
        .reqForce16(reqForce16), .reqWaitStates(reqWaitStates),
        .reqReady(reqReady), .rspDone(rspDone), .rspRdData(rdData),
        .rspWide(rspWide), .emulatorFloatMode(emu), .bootRomWide(bootW),
        .systemAddressBus(sysAddr), .addressOeN(aOeN),
        .addrStrapIn(aOeN ? strapA0 : sysAddr[0]), .systemDataBusIn(sdBus),
        .systemDataBusOut(dOut), .systemDataBusOeN(dOeN),
        .highByteStrobeIn(hbOeN ? strapHb : hbN), .highByteStrobeN(hbN),
        .highByteStrobeOeN(hbOeN), .ioReadStrobeN(iorN),
        .ioWriteStrobeN(iowN), .memReadStrobeN(memrN),
        .memWriteStrobeN(memwN), .wideDeviceFeedbackOut(fbOut),
        .wideDeviceFeedbackIn(!((!fbOeN && !fbOut) || fbPull)),
        .wideDeviceFeedbackOeN(fbOeN), .readyIn(!rdyPull));
    // floated command pins read idle through the board pull-ups
    isb_periph_model model_u (.clk(clk), .addr(sysAddr), .iorN(aOeN | iorN),
        .iowN(aOeN | iowN), .memrN(aOeN | memrN), .memwN(aOeN | memwN),
        .hbN(hbOeN | hbN), .dataIn(sdBus), .dataOut(mOut), .dataOe(mOe),
        .fbPull(fbPull), .rdyPull(rdyPull));
    initial forever #20 clk = ~clk;
    // hang guard: the whole run needs well under two hundred cycles
    always @(posedge clk) begin
        sdLast <= sdBus;
        cycles++;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end
    task automatic summarize();
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic doReset(input logic a0, hb);
        int g = 0;
        @(posedge clk);
        sys_rst <= 1;
        strapA0 <= a0;
        strapHb <= hb;
        repeat (1) @(posedge clk);
        @(negedge clk);
        chk("pins idle", 32'hFF, {aOeN, dOeN, hbOeN, fbOeN, iorN, iowN,
            memrN, memwN});
        chk("ready in reset", 32'h0, reqReady);
        @(posedge clk);
        sys_rst <= 0;
        while (reqReady !== 1'b1 && g < 8) begin
            @(negedge clk);
            g++;
        end
        chk("float strap", !a0, emu);
        chk("boot strap", !hb, bootW);
    endtask
    // one whole access; records what the pins did until completion
    task automatic run(input logic [2:0] k, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic hb, f16,
        input logic [WAIT_W-1:0] w, input logic [2:0] c);
        int g = 0;
        while (reqReady !== 1'b1 && g < 20) begin
            @(negedge clk);
            g++;
        end
        @(posedge clk);
        reqValid <= 1;
        reqKind <= k;
        reqAddr <= a;
        reqWrData <= d;
        reqHighByte <= hb;
        reqForce16 <= f16;
        reqWaitStates <= w;
        reqCascade <= c;
        @(posedge clk);
        reqValid <= 0;
        {lat, stb, hbSeen, fbSeen, oeSeen} = '0;
        do begin
            @(negedge clk);
            lat++;
            stb |= ~{iorN, iowN, memrN, memwN};
            hbSeen |= !hbN && !hbOeN;
            fbSeen |= !fbOeN;
            oeSeen |= !aOeN || !dOeN;
            if (lat == 1) a1 = sysAddr;
            if (lat == 2) a2 = sysAddr;
        end while (rspDone !== 1'b1 && lat < 60);
    endtask
    task automatic t_kinds();
        logic [3:0] want [7] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h0, 4'h0};
        for (int k = 0; k < 7; k++) begin
            run(3'(k), 26'h0000010, 16'h0000, 0, 0, 4'h0, 3'h0);
            chk("strobes", want[k], stb);
            chk("latency", 32'h5, lat);
            if (k < 4) chk("address", 26'h0000010, a2);
        end
    endtask
    task automatic t_wide();
        run(3'h1, 26'h0100004, 16'hA55A, 1, 0, 4'h0, 3'h0);
        chk("high strobe", 32'h1, hbSeen);
        run(3'h0, 26'h0100004, 16'h0000, 1, 0, 4'h0, 3'h0);
        chk("wide data", 32'hA55A, rdData);
        chk("wide flag", 32'h1, rspWide);
    endtask
    task automatic t_narrow();
        run(3'h3, 26'h0000006, 16'h1234, 1, 0, 4'h0, 3'h0);
        chk("narrow wr flag", 32'h0, rspWide);
        run(3'h2, 26'h0000006, 16'h0000, 1, 0, 4'h0, 3'h0);
        chk("narrow data", 32'h0034, rdData);
        chk("narrow flag", 32'h0, rspWide);
        chk("no own pull", 32'h0, fbSeen);
        run(3'h2, 26'h0000006, 16'h0000, 1, 1, 4'h0, 3'h0);
        chk("forced pull", 32'h1, fbSeen);
        chk("forced wide", 32'h1, rspWide);
    endtask
    task automatic t_waits();
        run(3'h0, 26'h0000010, 16'h0000, 0, 0, 4'h2, 3'h0);
        chk("programmed waits", 32'h7, lat);
        run(3'h0, 26'h0200010, 16'h0000, 0, 0, 4'h0, 3'h0);
        chk("ready stretch", 32'h1, lat > 5 && lat < 20);
    endtask
    task automatic t_addr();
        run(3'h4, 26'h0000000, 16'h0000, 0, 0, 4'h0, 3'h5);
        chk("cascade", 32'h5, a1[25:23]);
        run(3'h5, 26'h0D34566, 16'h0000, 0, 0, 4'h0, 3'h0);
        chk("dram row", 32'h69A, a1[12:1]);
        chk("dram column", 32'h2B3, a2[12:1]);
    endtask
    task automatic t_float();
        doReset(0, 1);
        run(3'h1, 26'h0000010, 16'h5A5A, 1, 0, 4'h0, 3'h0);
        chk("float pins", 32'h0, oeSeen);
        chk("float latency", 32'h5, lat);
    endtask
    initial begin
        doReset(1, 0);
        t_kinds();
        t_wide();
        t_narrow();
        t_waits();
        t_addr();
        t_float();
        summarize();
    end
endmodule
`default_nettype wire
